/* hdl/idle_pb_pkg.sv */
// shared constants for the idle mode and peripheral bus clock controller
package idle_pb_pkg;

    // ****************************************
    // register map (byte addresses, word aligned)
    // ****************************************
    localparam logic [7:0] OSC_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] STOP_IDLE_OFFSET = 8'h08;
    localparam logic [7:0] WDT_CTRL_OFFSET = 8'h0C;
    localparam logic [7:0] CFG_WORD_OFFSET = 8'h10;
    localparam logic [7:0] PB_SCRATCH_OFFSET = 8'h14;

    // ****************************************
    // oscillator control register fields
    // ****************************************
    localparam int OSC_SWITCH_BIT = 0;
    localparam int OSC_NEEDS_START_BIT = 1;
    localparam int OSC_SLEEP_EN_BIT = 4;
    localparam int OSC_DIV_LSB = 19;
    localparam int OSC_DIV_MSB = 20;
    localparam logic [1:0] DIV_RESET = 2'h0;

    // ****************************************
    // status register fields
    // ****************************************
    localparam int STAT_IDLE_BIT = 0;
    localparam int STAT_SWITCH_BUSY_BIT = 1;
    localparam int STAT_WDT_EN_BIT = 2;

    // ****************************************
    // device configuration word one fields
    // ****************************************
    localparam int CFG_WIN_LSB = 24;
    localparam int CFG_WIN_MSB = 25;
    localparam int CFG_FORCE_EN_BIT = 23;
    localparam int CFG_WIN_DIS_BIT = 22;
    localparam int CFG_PS_LSB = 16;
    localparam int CFG_PS_MSB = 20;
    localparam logic [4:0] PS_CODE_MAX = 5'h14;
    localparam logic [9:0] WIN_PCT10_25 = 10'h0FA;
    localparam logic [9:0] WIN_PCT10_37P5 = 10'h177;
    localparam logic [9:0] WIN_PCT10_50 = 10'h1F4;
    localparam logic [9:0] WIN_PCT10_75 = 10'h2EE;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 10000000;
    localparam int OSC_STARTUP_US = 100;
    localparam int OSC_STARTUP_CYCLES = (OSC_STARTUP_US * (CLK_HZ / 1000000) > 0) ?
                                        OSC_STARTUP_US * (CLK_HZ / 1000000) : 1;

    // idle controller states, one-hot
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_IDLE = 2'b10
    } idle_state_e;

endpackage

/* hdl/pb_clock_divider.sv */
// peripheral bus clock enable generator, ratio 1:1 to 1:8
`timescale 1ns/1ps
module pb_clock_divider (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_divisor,
    output logic o_tick
);

    logic [2:0] cnt_r;
    logic [2:0] limit;

    // binary divisor code to terminal count
    always_comb begin
        case (i_divisor)
            2'h0: limit = 3'h0;
            2'h1: limit = 3'h1;
            2'h2: limit = 3'h3;
            2'h3: limit = 3'h7;
            default: limit = 3'h0;
        endcase
    end

    // a divisor change takes effect at once: a count already past the new
    // limit ends the period, so no period is ever longer than eight cycles
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt_r >= limit);
            if (cnt_r >= limit) begin
                cnt_r <= 3'h0;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end

endmodule

/* hdl/wdt_config_decoder.sv */
// decodes the watchdog fields of configuration word one
`timescale 1ns/1ps
module wdt_config_decoder
    import idle_pb_pkg::*;
(
    input wire logic [31:0] i_cfg,
    output logic [9:0] o_window_pct10,
    output logic o_force_enable,
    output logic o_window_mode,
    output logic [4:0] o_postscale_exp
);

    logic [4:0] ps_code;

    // window size in tenths of a percent
    always_comb begin
        case (i_cfg[CFG_WIN_MSB:CFG_WIN_LSB])
            2'h3: o_window_pct10 = WIN_PCT10_25;
            2'h2: o_window_pct10 = WIN_PCT10_37P5;
            2'h1: o_window_pct10 = WIN_PCT10_50;
            2'h0: o_window_pct10 = WIN_PCT10_75;
            default: o_window_pct10 = WIN_PCT10_75;
        endcase
    end

    // enable and window mode flags; postscale clamps at the top code
    always_comb begin
        o_force_enable = i_cfg[CFG_FORCE_EN_BIT];
        o_window_mode = ~i_cfg[CFG_WIN_DIS_BIT];
        ps_code = i_cfg[CFG_PS_MSB:CFG_PS_LSB];
        o_postscale_exp = (ps_code > PS_CODE_MAX) ? PS_CODE_MAX : ps_code;
    end

endmodule

/* hdl/idle_pb_clock_ctrl.sv */
// idle mode controller, peripheral bus clock divider and watchdog config decode
//
// Operation
// R1 - in idle the cpu halts while the system clock keeps running
// R2 - a peripheral with its stop-in-idle bit set stops during idle
// R3 - wait instruction with sleep enable clear enters idle
// R4 - enabled interrupt above cpu priority wakes from idle
// R5 - enabled interrupt at or below cpu priority leaves the cpu halted
// R6 - any reset or a watchdog time-out also leaves idle
// R7 - switch to stopped crystal or pll source waits start-up; idle exit waits not
// R8 - two-bit divisor at bits 20:19 sets ratio 1:1, 1:2, 1:4, 1:8
// R9 - only peripheral bus logic follows the divisor; system clock users do not
// R10 - peripheral read completes at next peripheral clock edge
// R11 - software picks the largest divisor giving acceptable performance
// R12 - software recomputes peripheral timing after divisor change
// R13 - window field 11/10/01/00 gives 25, 37.5, 50, 75 percent
// R14 - config bit 23 forces watchdog on; clear leaves it to software
// R15 - config bit 22 set means non-window mode, clear window mode
// R16 - five-bit postscale field selects powers of two up to 1:1048576
// R17 - postscale codes above the top code act as the top code
// R18 - reserved configuration bits are programmed to one
// R19 - software keeps the primary oscillator on while it is selected
// R20 - divisor codes 00, 01, 10, 11 mean 1:1, 1:2, 1:4, 1:8
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module idle_pb_clock_ctrl
    import idle_pb_pkg::*;
#(
    parameter int NUM_PERIPH = 8,
    parameter int STARTUP_CYCLES = OSC_STARTUP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // cpu side events
    input wire logic i_wait_instr,
    input wire logic i_irq_valid,
    input wire logic i_irq_enabled,
    input wire logic [2:0] i_irq_priority,
    input wire logic [2:0] i_cpu_priority,
    input wire logic i_wdt_timeout,
    // programmed configuration word, static after power-up
    input wire logic [31:0] i_config_word,
    // clock and idle outputs
    output logic o_cpu_halt,
    output logic o_idle,
    output logic o_pb_clk_en,
    output logic [NUM_PERIPH-1:0] o_periph_clk_en,
    output logic o_clk_switch_busy,
    output logic o_clk_switch_done,
    // watchdog configuration
    output logic o_wdt_enable,
    output logic o_wdt_window_mode,
    output logic [9:0] o_wdt_window_pct10,
    output logic [4:0] o_wdt_postscale_exp
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_bad_num_periph
        $error("NUM_PERIPH must lie between 1 and 32");
    end
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_bad_startup
        $error("STARTUP_CYCLES must lie between 1 and 65535");
    end

    // ****************************************
    // declarations
    // ****************************************
    idle_state_e state_r;
    idle_state_e state_nxt;
    logic sleep_en_r;
    logic needs_start_r;
    logic [1:0] div_r;
    logic [NUM_PERIPH-1:0] stop_idle_r;
    logic wdt_sw_en_r;
    logic [31:0] cfg_r;
    logic cfg_loaded_r;
    logic [31:0] pb_scratch_r;
    logic [15:0] start_cnt_r;
    logic pb_tick;
    logic wake;
    logic req;
    logic done;
    logic ready;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] rd_mux;
    logic [31:0] osc_word;
    logic [9:0] win_pct10;
    logic force_en;
    logic window_mode;
    logic [4:0] ps_exp;

    // ****************************************
    // sub-blocks
    // ****************************************

    // peripheral bus clock enable from the divisor field
    pb_clock_divider u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_divisor(div_r),
        .o_tick(pb_tick)
    );

    // watchdog fields of the captured configuration word
    wdt_config_decoder u_cfg (
        .i_cfg(cfg_r),
        .o_window_pct10(win_pct10),
        .o_force_enable(force_en),
        .o_window_mode(window_mode),
        .o_postscale_exp(ps_exp)
    );

    // ****************************************
    // bus handshake
    // ****************************************

    // byte enables widen to a bit mask for writes
    always_comb begin
        wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                 {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    end

    // request is live until the edge where waitrequest is seen low
    assign req = i_read | i_write;
    assign done = req & ~o_waitrequest;
    assign wr_en = i_write & done;

    // peripheral bus registers answer only on a peripheral clock edge
    assign ready = (i_address == PB_SCRATCH_OFFSET) ? pb_tick : 1'b1; // [R10]

    // waitrequest idles high and drops for exactly one cycle per access
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_waitrequest <= 1'b1;
        end else begin
            o_waitrequest <= ~(req & o_waitrequest & ready);
        end
    end

    // ****************************************
    // oscillator control register
    // ****************************************

    // sleep enable and divisor fields, byte-lane masked
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sleep_en_r <= 1'b0;
            needs_start_r <= 1'b0;
            div_r <= DIV_RESET;
        end else if (wr_en && i_address == OSC_CTRL_OFFSET) begin
            if (wmask[OSC_SLEEP_EN_BIT]) begin
                sleep_en_r <= i_writedata[OSC_SLEEP_EN_BIT];
            end
            if (wmask[OSC_NEEDS_START_BIT]) begin
                needs_start_r <= i_writedata[OSC_NEEDS_START_BIT];
            end
            if (wmask[OSC_DIV_MSB]) begin
                div_r <= i_writedata[OSC_DIV_MSB:OSC_DIV_LSB]; // [R8] [R20]
            end
        end
    end

    // clock switch: a stopped crystal or pll source needs its start-up count;
    // a switch is requested by writing one to the switch bit and ignored while busy
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_cnt_r <= 16'h0000;
            o_clk_switch_busy <= 1'b0;
            o_clk_switch_done <= 1'b0;
        end else begin
            o_clk_switch_done <= 1'b0;
            if (o_clk_switch_busy) begin
                if (start_cnt_r == 16'h0001) begin
                    o_clk_switch_busy <= 1'b0;
                    o_clk_switch_done <= 1'b1;
                end
                start_cnt_r <= start_cnt_r - 16'h0001;
            end else if (wr_en && i_address == OSC_CTRL_OFFSET &&
                         wmask[OSC_SWITCH_BIT] && i_writedata[OSC_SWITCH_BIT]) begin
                if (i_writedata[OSC_NEEDS_START_BIT]) begin
                    start_cnt_r <= 16'(STARTUP_CYCLES); // [R7]
                    o_clk_switch_busy <= 1'b1;
                end else begin
                    o_clk_switch_done <= 1'b1; // [R7]
                end
            end
        end
    end

    // ****************************************
    // other software registers
    // ****************************************

    // per-peripheral stop-in-idle mask
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stop_idle_r <= '0;
        end else if (wr_en && i_address == STOP_IDLE_OFFSET) begin
            stop_idle_r <= (stop_idle_r & ~wmask[NUM_PERIPH-1:0]) |
                           (i_writedata[NUM_PERIPH-1:0] & wmask[NUM_PERIPH-1:0]);
        end
    end

    // software watchdog enable; when forced on the bit is moot
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wdt_sw_en_r <= 1'b0;
        end else if (wr_en && i_address == WDT_CTRL_OFFSET && wmask[0]) begin
            wdt_sw_en_r <= i_writedata[0];
        end
    end

    // scratch word living on the peripheral bus
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pb_scratch_r <= 32'h0000_0000;
        end else if (wr_en && i_address == PB_SCRATCH_OFFSET) begin
            pb_scratch_r <= (pb_scratch_r & ~wmask) | (i_writedata & wmask);
        end
    end

    // configuration word is caught once, in the first cycle after reset release
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_r <= 32'h0000_0000;
            cfg_loaded_r <= 1'b0;
        end else if (!cfg_loaded_r) begin
            cfg_r <= i_config_word;
            cfg_loaded_r <= 1'b1;
        end
    end

    // ****************************************
    // read path
    // ****************************************

    // osc control read-back; switch bit reads as busy
    always_comb begin
        osc_word = 32'h0000_0000;
        osc_word[OSC_SWITCH_BIT] = o_clk_switch_busy;
        osc_word[OSC_NEEDS_START_BIT] = needs_start_r;
        osc_word[OSC_SLEEP_EN_BIT] = sleep_en_r;
        osc_word[OSC_DIV_MSB:OSC_DIV_LSB] = div_r;
    end

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_address)
            OSC_CTRL_OFFSET: rd_mux = osc_word;
            STATUS_OFFSET: begin
                rd_mux[STAT_IDLE_BIT] = o_idle;
                rd_mux[STAT_SWITCH_BUSY_BIT] = o_clk_switch_busy;
                rd_mux[STAT_WDT_EN_BIT] = o_wdt_enable;
            end
            STOP_IDLE_OFFSET: rd_mux[NUM_PERIPH-1:0] = stop_idle_r;
            WDT_CTRL_OFFSET: rd_mux[0] = wdt_sw_en_r;
            CFG_WORD_OFFSET: rd_mux = cfg_r;
            PB_SCRATCH_OFFSET: rd_mux = pb_scratch_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is loaded as waitrequest drops and held until the next read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_readdata <= 32'h0000_0000;
        end else if (i_read && o_waitrequest && ready) begin
            o_readdata <= rd_mux;
        end
    end

    // ****************************************
    // idle state machine
    // ****************************************

    // wake needs strict priority; equal or lower keeps the cpu halted
    assign wake = i_wdt_timeout |
                  (i_irq_valid & i_irq_enabled & (i_irq_priority > i_cpu_priority)); // [R4] [R5] [R6]

    // sleep itself is out of scope: wait with sleep enable set does nothing here
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (i_wait_instr && !sleep_en_r) begin
                    state_nxt = ST_IDLE; // [R3]
                end
            end
            ST_IDLE: begin
                if (wake) begin
                    state_nxt = ST_RUN; // [R4] [R6]
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // synchronous reset is itself an idle exit; no start-up delay on wake
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ST_RUN; // [R6]
        end else begin
            state_r <= state_nxt; // [R7]
        end
    end

    // halt follows the state; the system clock is never gated here
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cpu_halt <= 1'b0;
            o_idle <= 1'b0;
        end else begin
            o_cpu_halt <= (state_nxt == ST_IDLE); // [R1] [R5]
            o_idle <= (state_nxt == ST_IDLE);
        end
    end

    // ****************************************
    // peripheral clock enables
    // ****************************************

    // only peripheral bus users see the divided enable; system clock users
    // such as dma and the interrupt controller take i_clk ungated
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pb_clk_en <= 1'b0;
            o_periph_clk_en <= '0;
        end else begin
            o_pb_clk_en <= pb_tick; // [R9] [R1]
            o_periph_clk_en <= {NUM_PERIPH{pb_tick}} &
                               ~({NUM_PERIPH{state_nxt == ST_IDLE}} & stop_idle_r); // [R2]
        end
    end

    // ****************************************
    // watchdog configuration outputs
    // ****************************************

    // forced enable overrides a software disable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wdt_enable <= 1'b0;
            o_wdt_window_mode <= 1'b0;
            o_wdt_window_pct10 <= 10'h000;
            o_wdt_postscale_exp <= 5'h00;
        end else begin
            o_wdt_enable <= force_en | wdt_sw_en_r; // [R14]
            o_wdt_window_mode <= window_mode; // [R15]
            o_wdt_window_pct10 <= win_pct10; // [R13]
            o_wdt_postscale_exp <= ps_exp; // [R16] [R17]
        end
    end

endmodule

/* bench/idle_pb_clock_ctrl_properties.sv */
// checker for the idle controller, peripheral clock divider and bus answer timing
`timescale 1ns/1ps
module idle_pb_clock_ctrl_properties #(
    parameter int NUM_PERIPH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_read,
    input wire logic o_waitrequest,
    input wire logic i_wait_instr,
    input wire logic i_irq_valid,
    input wire logic i_irq_enabled,
    input wire logic [2:0] i_irq_priority,
    input wire logic [2:0] i_cpu_priority,
    input wire logic i_wdt_timeout,
    input wire logic o_cpu_halt,
    input wire logic o_idle,
    input wire logic o_pb_clk_en,
    input wire logic [NUM_PERIPH-1:0] o_periph_clk_en,
    input wire logic o_clk_switch_busy,
    input wire logic o_clk_switch_done
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // qualifying wake request, only an enabled source above cpu priority counts
    logic wake;
    assign wake = i_irq_valid && i_irq_enabled && (i_irq_priority > i_cpu_priority);
    property p_halt_idle; o_cpu_halt == o_idle; endproperty
    a_halt_idle: assert property (p_halt_idle)
        else $error("cpu halt differs from idle state");
    property p_enter; $rose(o_idle) |-> $past(i_wait_instr); endproperty
    a_enter: assert property (p_enter)
        else $error("idle entered without a wait instruction");
    property p_wake; o_idle && wake |=> !o_idle; endproperty
    a_wake: assert property (p_wake)
        else $error("idle kept despite qualifying interrupt");
    property p_stay; o_idle && !wake && !i_wdt_timeout |=> o_idle; endproperty
    a_stay: assert property (p_stay)
        else $error("idle left without a wake event");
    property p_wdt; o_idle && i_wdt_timeout |=> !o_idle && !o_cpu_halt; endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog time-out did not end idle");
    property p_pb_tick; o_pb_clk_en |-> ##[1:8] o_pb_clk_en; endproperty
    a_pb_tick: assert property (p_pb_tick)
        else $error("peripheral clock edge missing for more than eight cycles");
    property p_run_en; !o_idle |-> o_periph_clk_en == {NUM_PERIPH{o_pb_clk_en}}; endproperty
    a_run_en: assert property (p_run_en)
        else $error("peripheral enable differs from bus clock while running");
    property p_read_wait; $rose(i_read) |-> ##[1:8] !o_waitrequest; endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read not answered within one peripheral period");
    property p_switch; $rose(o_clk_switch_busy) |-> ##[1:1000] o_clk_switch_done; endproperty
    a_switch: assert property (p_switch)
        else $error("clock switch start-up never completed");
    c_idle: cover property ($rose(o_idle));
    c_wake: cover property (o_idle && wake);
    c_busy: cover property ($rose(o_clk_switch_busy));
endmodule
bind idle_pb_clock_ctrl idle_pb_clock_ctrl_properties #(.NUM_PERIPH(NUM_PERIPH)) i_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_read(i_read), .o_waitrequest(o_waitrequest),
    .i_wait_instr(i_wait_instr), .i_irq_valid(i_irq_valid), .i_irq_enabled(i_irq_enabled),
    .i_irq_priority(i_irq_priority), .i_cpu_priority(i_cpu_priority),
    .i_wdt_timeout(i_wdt_timeout), .o_cpu_halt(o_cpu_halt), .o_idle(o_idle),
    .o_pb_clk_en(o_pb_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_clk_switch_busy(o_clk_switch_busy), .o_clk_switch_done(o_clk_switch_done));

/* bench/test_idle_pb_clock_ctrl.sv */
// self-checking testbench for the idle and peripheral bus clock controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module test_idle_pb_clock_ctrl;
    import idle_pb_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic i_clk, i_rst, i_read, i_write, i_wait_instr, i_irq_valid, i_irq_enabled;
    logic i_wdt_timeout, o_waitrequest, o_cpu_halt, o_idle, o_pb_clk_en;
    logic o_clk_switch_busy, o_clk_switch_done, o_wdt_enable, o_wdt_window_mode;
    logic [7:0] i_address, o_periph_clk_en;
    logic [31:0] i_writedata, i_config_word, o_readdata, q;
    logic [3:0] i_byteenable;
    logic [2:0] i_irq_priority, i_cpu_priority;
    logic [9:0] o_wdt_window_pct10;
    logic [4:0] o_wdt_postscale_exp;
    int miscompares = 0, n_tests = 0, n, nb;
    typedef struct {logic [31:0] cfg; logic [9:0] pct; logic wm; logic en; logic [4:0] ps;} row_s;
    // reserved bits held at one in every word, as the programmer must
    row_s rows[5] = '{'{32'hFC20_0000, 10'h2EE, 1'b1, 1'b0, 5'h00},
        '{32'hFE3F_0000, 10'h177, 1'b1, 1'b0, 5'h14}, '{32'hFD6A_0000, 10'h1F4, 1'b0, 1'b0, 5'h0A},
        '{32'hFC35_0000, 10'h2EE, 1'b1, 1'b0, 5'h14}, '{32'hFFF4_0000, 10'h0FA, 1'b0, 1'b1, 5'h14}};
    idle_pb_clock_ctrl #(.NUM_PERIPH(8), .STARTUP_CYCLES(4)) i_idle_pb_clock_ctrl (.*);
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // ****************************************
    // tasks
    // ****************************************
    task finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one avalon access; n counts edges until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do begin @(posedge i_clk); n++; end while (o_waitrequest !== 1'b0 && n < 50);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (n >= 50) begin miscompares++; finish_test; end
        @(posedge i_clk);
    endtask
    task reset(input logic [31:0] cfg);
        i_config_word <= cfg;
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk); // decoded config settles on the second edge
    endtask
    task enter_idle;
        i_wait_instr <= 1'b1;
        @(posedge i_clk);
        i_wait_instr <= 1'b0;
        @(posedge i_clk);
    endtask
    // edges between two peripheral ticks; the first wait skips a stale tick
    task gap;
        repeat (2) begin
            n = 0;
            do begin @(posedge i_clk); n++; end while (o_pb_clk_en !== 1'b1 && n < 20);
            if (n >= 20) begin miscompares++; finish_test; end
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {i_read, i_write, i_wait_instr, i_irq_valid, i_irq_enabled, i_wdt_timeout} = '0;
        {i_address, i_writedata, i_irq_priority, i_cpu_priority} = '0;
        i_byteenable = 4'hF;
        i_rst = 1'b1;
        i_config_word = '0;
        foreach (rows[k]) begin
            reset(rows[k].cfg);
            `CHK(o_wdt_window_pct10, rows[k].pct)
            `CHK(o_wdt_window_mode, rows[k].wm)
            `CHK(o_wdt_enable, rows[k].en)
            `CHK(o_wdt_postscale_exp, rows[k].ps)
            bus(1'b1, CFG_WORD_OFFSET, 32'h0000_0000);
            bus(1'b0, CFG_WORD_OFFSET, 32'h0000_0000);
            `CHK(q, rows[k].cfg)
        end
        // forced watchdog ignores a software disable
        bus(1'b1, WDT_CTRL_OFFSET, 32'h0000_0000);
        @(posedge i_clk);
        `CHK(o_wdt_enable, 1'b1)
        reset(rows[0].cfg);
        bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        bus(1'b1, WDT_CTRL_OFFSET, 32'h0000_0001);
        @(posedge i_clk);
        `CHK(o_wdt_enable, 1'b1)
        bus(1'b1, WDT_CTRL_OFFSET, 32'h0000_0000);
        @(posedge i_clk);
        `CHK(o_wdt_enable, 1'b0)
        // idle entry, clocks in idle, stop-in-idle mask
        bus(1'b1, STOP_IDLE_OFFSET, 32'h0000_000F);
        enter_idle;
        `CHK(o_idle, 1'b1)
        `CHK(o_cpu_halt, 1'b1)
        gap;
        `CHK(n, 1)
        `CHK(o_periph_clk_en, 8'hF0)
        i_irq_valid <= 1'b1;
        i_irq_enabled <= 1'b1;
        {i_irq_priority, i_cpu_priority} <= {3'h3, 3'h3};
        repeat (4) @(posedge i_clk);
        `CHK(o_idle, 1'b1)
        i_irq_enabled <= 1'b0;
        i_irq_priority <= 3'h7;
        repeat (4) @(posedge i_clk);
        `CHK(o_idle, 1'b1)
        i_irq_enabled <= 1'b1;
        repeat (2) @(posedge i_clk);
        `CHK(o_cpu_halt, 1'b0)
        i_irq_valid <= 1'b0;
        gap;
        `CHK(o_periph_clk_en, 8'hFF)
        enter_idle;
        i_wdt_timeout <= 1'b1;
        @(posedge i_clk);
        i_wdt_timeout <= 1'b0;
        @(posedge i_clk);
        `CHK(o_idle, 1'b0)
        // sleep enable set: the wait does not give idle
        bus(1'b1, OSC_CTRL_OFFSET, 32'h0000_0010);
        enter_idle;
        `CHK(o_idle, 1'b0)
        bus(1'b1, OSC_CTRL_OFFSET, 32'h0000_0000);
        enter_idle;
        reset(rows[0].cfg);
        `CHK(o_idle, 1'b0)
        // each divisor: tick spacing, peripheral access latency, system-side latency
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, OSC_CTRL_OFFSET, 32'(d) << OSC_DIV_LSB);
            gap;
            `CHK(n, 1 << d)
            bus(1'b1, PB_SCRATCH_OFFSET, 32'hA5A5_0000 + 32'(d));
            `CHK(n >= 2 && n <= (1 << d) + 1, 1'b1)
            bus(1'b0, PB_SCRATCH_OFFSET, 32'h0000_0000);
            `CHK(n >= 2 && n <= (1 << d) + 1, 1'b1)
            `CHK(q, 32'hA5A5_0000 + 32'(d))
            bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
            `CHK(n, 2)
        end
        bus(1'b0, 8'h1C, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        // divisor lane switched off: the divisor must keep 1:8
        i_byteenable <= 4'hB;
        bus(1'b1, OSC_CTRL_OFFSET, 32'h0000_0000);
        i_byteenable <= 4'hF;
        bus(1'b0, OSC_CTRL_OFFSET, 32'h0000_0000);
        `CHK(q[OSC_DIV_MSB:OSC_DIV_LSB], 2'h3)
        // clock switch with and without start-up delay
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, OSC_CTRL_OFFSET, s ? 32'h0000_0001 : 32'h0000_0003);
            nb = 0;
            n = 0;
            while (o_clk_switch_done !== 1'b1 && n < 50) begin
                nb += (o_clk_switch_busy === 1'b1);
                n++;
                @(posedge i_clk);
            end
            `CHK(nb, s ? 0 : 4)
            `CHK(n < 50, 1'b1)
            if (n >= 50) finish_test;
            @(posedge i_clk);
        end
        finish_test;
    end
endmodule
